// *** rtl/adc_sequencer.sv ***
/*
 * Successive-approximation converter sequencer with continuous digital
 * compare, register file on Avalon-MM, and analog core control.
 * Assumes an analog core whose comparator output settles within one
 * converter clock period of a new trial code being applied.
 */
// The Avalon-MM slave port was left to the implementer.
// Behaviour
// - on completion load result, set flag; flag level requests the interrupt.
// - exactly one of 14 inputs routes to the shared converter.
// - compare mode flags only when digitised input exceeds stored value.
// - compare mode repeats for as long as start stays set.
// - runs in idle, request wakes idle; inactive in power-down.
// - control bit 7 switches the converter off or on.
// - control bit 5 enables compare mode.
// - control bits 4..1 select input; 0..12 external, 13 reference.
// - writing start begins work; conversion completion clears it.
// - clearing start mid-conversion aborts the conversion.
// - in compare mode hardware never clears start.
// - timing bits 7..5 pick converter clock 2..32 system clocks.
// - timing bits 3..0 plus one give sample length.
// - sample length clamped between 2 and 15 converter clocks.
// - conversion takes 12 converter clocks after sampling.
// - 13-bit pin analog enable split across two registers.
// - bit 7 of second pin register enables reference source.
// - result high byte holds upper eight bits, low nibble lower four.
// - in compare mode result registers are the threshold.
`timescale 1ns/1ps
module adc_sequencer (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// avalon-mm register slave
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// power state from the clock controller
	input wire logic i_power_down,
	// analog core
	input wire logic i_cmp_above,
	output logic o_core_enable,
	output logic o_sample,
	output logic [3:0] o_channel_sel,
	output logic [11:0] o_trial_code,
	output logic [12:0] o_pin_analog_enable,
	output logic o_reference_enable,
	// interrupt request to the system
	output logic o_irq_request
);

	// register contents
	logic [7:0] control_reg;
	logic [2:0] div_code_reg;
	logic [3:0] sample_len_reg;
	logic [12:0] pin_enable_reg;
	logic ref_enable_reg;
	logic [7:0] result_high_reg;
	logic [3:0] result_low_reg;

	// bus slave state
	logic wait_reg;
	logic [31:0] readdata_reg;
	logic [31:0] readdata_next;

	// sequencer state
	adc_ctrl_pkg::seq_state_e state_reg;
	logic [4:0] period_cnt_reg;
	logic [3:0] bit_idx_reg;
	logic [11:0] acc_reg;
	logic [3:0] channel_reg;
	logic sample_reg;
	logic core_en_reg;

	// comparator synchroniser
	logic [2:0] cmp_sync_reg;
	logic cmp_level_reg;

	// events from the sequencer
	logic conv_done;
	logic cmp_hit;
	logic keep_going;
	logic [4:0] sample_periods;
	logic [11:0] threshold;
	logic [11:0] acc_decided;
	logic [11:0] trial_mask;

	conv_tick_if tk ();

	conv_clock_div u_div (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.tk(tk.div)
	);

	// divider runs only while sampling or converting
	assign tk.run = (state_reg != adc_ctrl_pkg::ST_IDLE);
	assign tk.code = div_code_reg;

	// bus write strobe: taken at the edge where waitrequest is low
	logic bus_wr;
	assign bus_wr = i_avs_write && !wait_reg && i_avs_byteenable[0];

	// clamped sample length in converter clocks
	always_comb begin
		sample_periods = {1'b0, sample_len_reg} + {1'b0, adc_ctrl_pkg::SAMPLE_ONE};
		if (sample_periods < adc_ctrl_pkg::SAMPLE_MIN) begin
			sample_periods = adc_ctrl_pkg::SAMPLE_MIN;
		end
		if (sample_periods > adc_ctrl_pkg::SAMPLE_MAX) begin
			sample_periods = adc_ctrl_pkg::SAMPLE_MAX;
		end
	end

	// threshold read straight from the result registers
	assign threshold = {result_high_reg, result_low_reg};

	// current trial bit and the decided accumulator for this period
	assign trial_mask = 12'h001 << bit_idx_reg;
	assign acc_decided = cmp_level_reg ? acc_reg : (acc_reg & ~trial_mask);

	// work may continue only while enabled, started and powered
	assign keep_going = control_reg[adc_ctrl_pkg::CTL_ON]
		&& control_reg[adc_ctrl_pkg::CTL_START] && !i_power_down;

	// completion events on the last converter clock of a conversion
	assign conv_done = (state_reg == adc_ctrl_pkg::ST_CONVERT) && tk.tick
		&& keep_going && (bit_idx_reg == 4'h0);
	assign cmp_hit = conv_done && control_reg[adc_ctrl_pkg::CTL_CMP]
		&& (acc_decided > threshold);

	// comparator input: three stages, a change counts when two agree
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmp_sync_reg <= 3'h0;
			cmp_level_reg <= 1'b0;
		end else begin
			cmp_sync_reg <= {cmp_sync_reg[1:0], i_cmp_above};
			if (cmp_sync_reg[1] == cmp_sync_reg[2]) begin
				cmp_level_reg <= cmp_sync_reg[2];
			end
		end
	end

	// sequencer: idle, sample, then one bit decision per converter clock
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= adc_ctrl_pkg::ST_IDLE;
			period_cnt_reg <= 5'h00;
			bit_idx_reg <= 4'h0;
			acc_reg <= 12'h000;
			channel_reg <= 4'h0;
			sample_reg <= 1'b0;
		end else begin
			case (state_reg)
				adc_ctrl_pkg::ST_IDLE: begin
					sample_reg <= 1'b0;
					if (keep_going) begin
						state_reg <= adc_ctrl_pkg::ST_SAMPLE;
						channel_reg <= control_reg[adc_ctrl_pkg::CTL_SEL_HI:
							adc_ctrl_pkg::CTL_SEL_LO];
						period_cnt_reg <= sample_periods;
						sample_reg <= 1'b1;
					end
				end
				adc_ctrl_pkg::ST_SAMPLE: begin
					if (!keep_going) begin
						state_reg <= adc_ctrl_pkg::ST_IDLE;
						sample_reg <= 1'b0;
					end else if (tk.tick) begin
						if (period_cnt_reg == 5'h01) begin
							state_reg <= adc_ctrl_pkg::ST_CONVERT;
							sample_reg <= 1'b0;
							bit_idx_reg <= adc_ctrl_pkg::CONV_PERIODS - 4'h1;
							acc_reg <= 12'h800;
						end else begin
							period_cnt_reg <= period_cnt_reg - 5'h01;
						end
					end
				end
				adc_ctrl_pkg::ST_CONVERT: begin
					if (!keep_going) begin
						state_reg <= adc_ctrl_pkg::ST_IDLE;
					end else if (tk.tick) begin
						if (bit_idx_reg == 4'h0) begin
							acc_reg <= acc_decided;
							if (control_reg[adc_ctrl_pkg::CTL_CMP]) begin
								// compare mode samples again at once
								state_reg <= adc_ctrl_pkg::ST_SAMPLE;
								period_cnt_reg <= sample_periods;
								sample_reg <= 1'b1;
							end else begin
								state_reg <= adc_ctrl_pkg::ST_IDLE;
							end
						end else begin
							bit_idx_reg <= bit_idx_reg - 4'h1;
							acc_reg <= acc_decided | (trial_mask >> 1);
						end
					end
				end
				default: begin
					state_reg <= adc_ctrl_pkg::ST_IDLE;
					sample_reg <= 1'b0;
				end
			endcase
		end
	end

	// control register: set of the flag wins over a software clear
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			control_reg <= adc_ctrl_pkg::RST_BYTE;
		end else begin
			if (bus_wr && i_avs_address == adc_ctrl_pkg::IDX_CONTROL) begin
				control_reg[adc_ctrl_pkg::CTL_ON] <=
					i_avs_writedata[adc_ctrl_pkg::CTL_ON];
				control_reg[adc_ctrl_pkg::CTL_CMP] <=
					i_avs_writedata[adc_ctrl_pkg::CTL_CMP];
				control_reg[adc_ctrl_pkg::CTL_SEL_HI:adc_ctrl_pkg::CTL_SEL_LO] <=
					i_avs_writedata[adc_ctrl_pkg::CTL_SEL_HI:
					adc_ctrl_pkg::CTL_SEL_LO];
				// a fresh software write of start beats the hardware clear
				control_reg[adc_ctrl_pkg::CTL_START] <=
					i_avs_writedata[adc_ctrl_pkg::CTL_START];
				// software may only clear the flag; hardware set wins
				control_reg[adc_ctrl_pkg::CTL_FLAG] <= (conv_done
					&& (!control_reg[adc_ctrl_pkg::CTL_CMP] || cmp_hit))
					|| (control_reg[adc_ctrl_pkg::CTL_FLAG]
					&& i_avs_writedata[adc_ctrl_pkg::CTL_FLAG]);
			end else begin
				if (conv_done && (!control_reg[adc_ctrl_pkg::CTL_CMP] || cmp_hit)) begin
					control_reg[adc_ctrl_pkg::CTL_FLAG] <= 1'b1;
				end
				if (conv_done && !control_reg[adc_ctrl_pkg::CTL_CMP]) begin
					control_reg[adc_ctrl_pkg::CTL_START] <= 1'b0;
				end
			end
		end
	end

	// timing and pin configuration registers
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_code_reg <= 3'h0;
			sample_len_reg <= 4'h0;
			pin_enable_reg <= 13'h0000;
			ref_enable_reg <= 1'b0;
		end else if (bus_wr) begin
			case (i_avs_address)
				adc_ctrl_pkg::IDX_TIMING: begin
					div_code_reg <= i_avs_writedata[adc_ctrl_pkg::TIM_DIV_HI:
						adc_ctrl_pkg::TIM_DIV_LO];
					sample_len_reg <= i_avs_writedata[adc_ctrl_pkg::TIM_LEN_HI:
						adc_ctrl_pkg::TIM_LEN_LO];
				end
				adc_ctrl_pkg::IDX_PIN_SEL_LOW: begin
					pin_enable_reg[7:0] <= i_avs_writedata[7:0];
				end
				adc_ctrl_pkg::IDX_PIN_SEL_HIGH: begin
					pin_enable_reg[adc_ctrl_pkg::NUM_PINS-1:8] <=
						i_avs_writedata[adc_ctrl_pkg::PSH_PINS_HI:0];
					ref_enable_reg <= i_avs_writedata[adc_ctrl_pkg::PSH_REF];
				end
				default: begin
				end
			endcase
		end
	end

	// result registers: a finished conversion outside compare mode beats a software write
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			result_high_reg <= adc_ctrl_pkg::RST_BYTE;
			result_low_reg <= 4'h0;
		end else if (conv_done && !control_reg[adc_ctrl_pkg::CTL_CMP]) begin
			result_high_reg <= acc_decided[adc_ctrl_pkg::RES_W-1:
				adc_ctrl_pkg::LOW_NIB_W];
			result_low_reg <= acc_decided[adc_ctrl_pkg::LOW_NIB_W-1:0];
		end else if (bus_wr && i_avs_address == adc_ctrl_pkg::IDX_RESULT_HIGH) begin
			result_high_reg <= i_avs_writedata[7:0];
		end else if (bus_wr && i_avs_address == adc_ctrl_pkg::IDX_RESULT_LOW) begin
			result_low_reg <= i_avs_writedata[adc_ctrl_pkg::LOW_NIB_W-1:0];
		end
	end

	// read mux; reserved bits and unmapped words read zero
	always_comb begin
		readdata_next = 32'h0000_0000;
		case (i_avs_address)
			adc_ctrl_pkg::IDX_CONTROL: readdata_next[7:0] = control_reg;
			adc_ctrl_pkg::IDX_TIMING: readdata_next[7:0] =
				{div_code_reg, 1'b0, sample_len_reg};
			adc_ctrl_pkg::IDX_PIN_SEL_LOW: readdata_next[7:0] =
				pin_enable_reg[7:0];
			adc_ctrl_pkg::IDX_PIN_SEL_HIGH: readdata_next[7:0] =
				{ref_enable_reg, 2'b00, pin_enable_reg[12:8]};
			adc_ctrl_pkg::IDX_RESULT_LOW: readdata_next[7:0] =
				{4'h0, result_low_reg};
			adc_ctrl_pkg::IDX_RESULT_HIGH: readdata_next[7:0] = result_high_reg;
			default: readdata_next = 32'h0000_0000;
		endcase
	end

	// one wait cycle per access; read data captured as wait drops
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wait_reg <= 1'b1;
			readdata_reg <= 32'h0000_0000;
		end else if (wait_reg && (i_avs_read || i_avs_write)) begin
			wait_reg <= 1'b0;
			readdata_reg <= readdata_next;
		end else begin
			wait_reg <= 1'b1;
		end
	end

	// core enable as a registered level so the pin never glitches
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			core_en_reg <= 1'b0;
		end else begin
			core_en_reg <= control_reg[adc_ctrl_pkg::CTL_ON] && !i_power_down;
		end
	end

	// outputs, all from flip-flops
	assign o_avs_waitrequest = wait_reg;
	assign o_avs_readdata = readdata_reg;
	assign o_core_enable = core_en_reg;
	assign o_sample = sample_reg;
	assign o_channel_sel = channel_reg;
	assign o_trial_code = acc_reg;
	assign o_pin_analog_enable = pin_enable_reg;
	assign o_reference_enable = ref_enable_reg;
	// level request; the system interrupt enable gates it and wakes idle
	assign o_irq_request = control_reg[adc_ctrl_pkg::CTL_FLAG];

endmodule

// *** rtl/adc_ctrl_pkg.sv ***
/*
 * Shared constants for the converter sequencer: register indices, field
 * positions, reset values, divider table and sequencing counts.
 * Assumes a 32-bit Avalon-MM slave addressed by word index.
 */
package adc_ctrl_pkg;

	// register indices (word address on the slave port)
	localparam logic [7:0] IDX_PIN_SEL_HIGH = 8'h91;
	localparam logic [7:0] IDX_CONTROL = 8'h93;
	localparam logic [7:0] IDX_TIMING = 8'h94;
	localparam logic [7:0] IDX_PIN_SEL_LOW = 8'h95;
	localparam logic [7:0] IDX_RESULT_LOW = 8'h96;
	localparam logic [7:0] IDX_RESULT_HIGH = 8'h97;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// control register fields
	localparam int CTL_ON = 7;
	localparam int CTL_FLAG = 6;
	localparam int CTL_CMP = 5;
	localparam int CTL_SEL_HI = 4;
	localparam int CTL_SEL_LO = 1;
	localparam int CTL_START = 0;

	// timing register fields
	localparam int TIM_DIV_HI = 7;
	localparam int TIM_DIV_LO = 5;
	localparam int TIM_LEN_HI = 3;
	localparam int TIM_LEN_LO = 0;

	// pin select high register fields
	localparam int PSH_REF = 7;
	localparam int PSH_PINS_HI = 4;

	// widths and counts
	localparam int RES_W = 12;
	localparam int NUM_PINS = 13;
	localparam int LOW_NIB_W = 4;
	localparam logic [3:0] SEL_LAST_CODE = 4'hd;
	localparam logic [3:0] CONV_PERIODS = 4'hc;
	localparam logic [4:0] SAMPLE_MIN = 5'h02;
	localparam logic [4:0] SAMPLE_MAX = 5'h0f;
	localparam logic [3:0] SAMPLE_ONE = 4'h1;

	// converter clock period in system clocks, by divider code
	function automatic logic [5:0] div_period(input logic [2:0] code);
		case (code)
			3'h0: div_period = 6'h02;
			3'h1: div_period = 6'h04;
			3'h2: div_period = 6'h06;
			3'h3: div_period = 6'h08;
			3'h4: div_period = 6'h0c;
			3'h5: div_period = 6'h10;
			3'h6: div_period = 6'h18;
			default: div_period = 6'h20;
		endcase
	endfunction

	typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_e;

endpackage

// *** rtl/conv_tick_if.sv ***
/*
 * Carrier between the sequencer and its converter clock divider.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ps
interface conv_tick_if;
	logic run;
	logic [2:0] code;
	logic tick;

	modport seq (output run, output code, input tick);
	modport div (input run, input code, output tick);
endinterface

// *** rtl/conv_clock_div.sv ***
/*
 * Converter clock divider: one tick per converter clock period.
 * Assumes run drops between conversions so each one starts phase-aligned.
 */
`timescale 1ns/1ps
module conv_clock_div (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// sequencer side
	conv_tick_if.div tk
);

	logic [5:0] count_reg;
	logic tick_reg;

	// period counter, held at one while stopped
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_reg <= 6'h00;
			tick_reg <= 1'b0;
		end else if (!tk.run) begin
			// tick is registered: start one ahead so the first period is exact
			count_reg <= 6'h01;
			tick_reg <= 1'b0;
		end else if (count_reg == adc_ctrl_pkg::div_period(tk.code) - 6'h01) begin
			count_reg <= 6'h00;
			tick_reg <= 1'b1;
		end else begin
			count_reg <= count_reg + 6'h01;
			tick_reg <= 1'b0;
		end
	end

	assign tk.tick = tick_reg;

endmodule

// *** verif/adc_sequencer_sva.sv ***
/* checker on the sequencer top ports: bus handshake, flag, power, pins.
   assumes one clock domain and the asynchronous active-low reset. */
`timescale 1ns/1ps
module adc_sequencer_sva (
	// clock, reset and bus
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	// power and core side
	input wire logic i_power_down,
	input wire logic o_core_enable,
	input wire logic o_sample,
	input wire logic [3:0] o_channel_sel,
	input wire logic [12:0] o_pin_analog_enable,
	input wire logic o_reference_enable,
	input wire logic o_irq_request
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// accepted write: the edge where the master sees waitrequest low
	wire acc = !o_avs_waitrequest;
	wire wr_ok = i_avs_write && acc && i_avs_byteenable[0];
	wire unmapped = i_avs_address < 8'h91 || i_avs_address > 8'h97
		|| i_avs_address == 8'h92;

	a_wait_one_cycle: assert property ((i_avs_read || i_avs_write)
		&& o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("waitrequest did not drop after one cycle");
	a_wait_single_low: assert property (acc |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_rdata_upper_zero: assert property (acc |-> o_avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_unmapped_read_zero: assert property (i_avs_read && acc && unmapped
		|-> o_avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_flag_sw_clear: assert property (o_irq_request
		&& !(wr_ok && i_avs_address == 8'h93) |=> o_irq_request)
		else $error("flag dropped without a software write");
	a_pdown_no_sample: assert property (i_power_down |=> !o_sample)
		else $error("sampling during power-down");
	a_pdown_core_off: assert property (i_power_down |=> !o_core_enable)
		else $error("core enabled during power-down");
	a_channel_legal: assert property (o_sample |-> o_channel_sel <= 4'hd)
		else $error("illegal input selected");
	a_channel_held: assert property (o_sample && $past(o_sample)
		|-> $stable(o_channel_sel))
		else $error("input changed while sampling");
	a_pins_low_follow: assert property (wr_ok && i_avs_address == 8'h95
		|-> ##2 o_pin_analog_enable[7:0] == $past(i_avs_writedata[7:0], 2))
		else $error("low pin enables not updated");
	a_pins_high_follow: assert property (wr_ok && i_avs_address == 8'h91
		|-> ##2 {o_reference_enable, o_pin_analog_enable[12:8]}
		== {$past(i_avs_writedata[7], 2), $past(i_avs_writedata[4:0], 2)})
		else $error("high pin enables or reference not updated");

	c_done: cover property ($rose(o_irq_request));
	c_sample_end: cover property ($fell(o_sample));
	c_unmapped_read: cover property (i_avs_read && acc && unmapped);
endmodule

bind adc_sequencer adc_sequencer_sva u_adc_sequencer_sva (
	.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.i_power_down(i_power_down), .o_core_enable(o_core_enable),
	.o_sample(o_sample), .o_channel_sel(o_channel_sel),
	.o_pin_analog_enable(o_pin_analog_enable),
	.o_reference_enable(o_reference_enable), .o_irq_request(o_irq_request));

// *** verif/adc_core_model.sv ***
/* analog core stand-in: one level per input, comparator on trial code.
   assumes the bench sets the levels before any work starts. */
`timescale 1ns/1ps
module adc_core_model (
	// clock and control from the sequencer
	input wire logic i_ref_clk,
	input wire logic i_core_enable,
	input wire logic [3:0] i_channel_sel,
	input wire logic [11:0] i_trial_code,
	// analog levels and comparator
	input wire logic [11:0] i_levels [14],
	output logic o_cmp_above
);
	logic toggle_reg = 1'b0;
	// a switched-off core gives no stable answer, so never repeat one
	always @(posedge i_ref_clk) begin
		toggle_reg <= !toggle_reg;
	end
	// only the selected input reaches the comparator
	always_comb begin
		if (i_core_enable && i_channel_sel <= 4'hd) begin
			o_cmp_above = i_trial_code <= i_levels[i_channel_sel];
		end else begin
			o_cmp_above = toggle_reg;
		end
	end
endmodule

// *** verif/adc_sequencer_tb_top.sv ***
/* bench for the converter sequencer: avalon tasks and an analog stand-in.
   assumes one 40 MHz clock and the registered bus answer of the slave. */
`timescale 1ns/1ps
module adc_sequencer_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'h1;
	logic pdown = 1'b0;
	logic cmp, wait_req, core_en, smp, ref_en, irq;
	logic [31:0] rdata;
	logic [3:0] ch_sel;
	logic [11:0] trial;
	logic [12:0] pins;
	logic [11:0] levels [14];
	int err_total = 0;
	int comparisons = 0;
	int per [8] = '{2, 4, 6, 8, 12, 16, 24, 32};
	int lens [8] = '{0, 1, 4, 7, 9, 13, 14, 15};

	adc_sequencer u_adc_sequencer (.i_ref_clk(clk), .i_rst_n(rst_n),
		.i_avs_address(addr), .i_avs_read(rd_en), .i_avs_write(wr_en),
		.i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
		.i_power_down(pdown), .i_cmp_above(cmp), .o_core_enable(core_en),
		.o_sample(smp), .o_channel_sel(ch_sel), .o_trial_code(trial),
		.o_pin_analog_enable(pins), .o_reference_enable(ref_en),
		.o_irq_request(irq));
	adc_core_model u_adc_core_model (.i_ref_clk(clk), .i_core_enable(core_en),
		.i_channel_sel(ch_sel), .i_trial_code(trial), .i_levels(levels),
		.o_cmp_above(cmp));

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// one access, held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= {24'h0, d};
		rd_en <= !w;
		wr_en <= w;
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 50);
		q = rdata[7:0];
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		if (n >= 50) begin
			err_total++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		check({24'h0, q}, {24'h0, exp});
	endtask

	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) begin
			err_total++;
			complete_run();
		end
	endtask

	// one conversion: cycles of sampling, then cycles until the flag
	task automatic run_conv(input int ch, input int dc, input int ln,
		output int s_len, output int c_len);
		int n;
		wr(8'h94, {3'(dc), 1'b0, 4'(ln)});
		wr(8'h93, {3'b100, 4'(ch), 1'b1});
		n = 0;
		s_len = 0;
		while (smp !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		while (smp === 1'b1 && s_len < 1000) begin
			@(posedge clk);
			s_len++;
		end
		check({20'h0, trial}, 32'h800);
		c_len = 0;
		while (irq !== 1'b1 && c_len < 1000) begin
			@(posedge clk);
			c_len++;
		end
		if (n >= 100 || s_len >= 1000 || c_len >= 1000) begin
			err_total++;
			complete_run();
		end
	endtask

	initial begin
		int s_len, c_len, dc, ln, p, ch, k;
		logic [11:0] th;
		for (k = 0; k < 14; k++) begin
			levels[k] = 12'h0a5 + 12'(k) * 12'h123;
		end
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		// reset values, reserved bits, unmapped place, masked write
		rdc(8'h91, 8'h00);
		rdc(8'h93, 8'h00);
		rdc(8'h94, 8'h00);
		rdc(8'h95, 8'h00);
		rdc(8'h97, 8'h00);
		wr(8'h92, 8'hff);
		rdc(8'h92, 8'h00);
		wr(8'h94, 8'hff);
		rdc(8'h94, 8'hef);
		wr(8'h96, 8'hff);
		rdc(8'h96, 8'h0f);
		be <= 4'h0;
		wr(8'h93, 8'hff);
		be <= 4'h1;
		rdc(8'h93, 8'h00);
		wr(8'h95, 8'ha5);
		wr(8'h91, 8'h9f);
		repeat (2) @(posedge clk);
		check({19'h0, pins}, 32'h1fa5);
		check({31'h0, ref_en}, 32'h1);
		$display("test registers done");
		// start with the converter off must not sample
		wr(8'h93, 8'h01);
		k = 0;
		repeat (60) begin
			@(posedge clk);
			k += (smp === 1'b1);
		end
		check(k, 0);
		wr(8'h93, 8'h00);
		$display("test off done");
		// every divider code and clamp end, then all fourteen inputs
		for (k = 0; k < 22; k++) begin
			dc = (k < 8) ? k : 3;
			ln = (k < 8) ? lens[k] : 1;
			ch = (k < 8) ? k + 6 : k - 8;
			p = per[dc];
			run_conv(ch, dc, ln, s_len, c_len);
			check(s_len, p * ((ln < 1) ? 2 : (ln > 13) ? 15 : ln + 1));
			check(c_len >= 12 * p && c_len <= 12 * p + 3, 1);
			check({31'h0, irq}, 32'h1);
			// slow codes only: fast ones leave the comparator no settling
			if (dc >= 3) begin
				rdc(8'h97, levels[ch][11:4]);
				rdc(8'h96, {4'h0, levels[ch][3:0]});
			end
			rdc(8'h93, {3'b110, 4'(ch), 1'b0});
			wr(8'h93, 8'h80);
			repeat (2) @(posedge clk);
			check({31'h0, irq}, 32'h0);
		end
		wr(8'h93, 8'hc0);
		rdc(8'h93, 8'h80);
		$display("test conversions done");
		// abort in mid conversion keeps the old result
		wr(8'h94, 8'he0);
		wr(8'h93, 8'h8b);
		repeat (150) @(posedge clk);
		wr(8'h93, 8'h8a);
		repeat (500) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		rdc(8'h97, levels[13][11:4]);
		// power-down in mid sampling stops everything
		wr(8'h93, 8'h8b);
		repeat (20) @(posedge clk);
		pdown <= 1'b1;
		repeat (3) @(posedge clk);
		check({30'h0, smp, core_en}, 32'h0);
		repeat (500) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		wr(8'h93, 8'h80);
		pdown <= 1'b0;
		$display("test abort done");
		// compare: equal is not above, one below the input is
		th = levels[4];
		wr(8'h97, th[11:4]);
		wr(8'h96, {4'h0, th[3:0]});
		wr(8'h94, 8'h60);
		wr(8'h93, 8'ha9);
		repeat (1500) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		rdc(8'h93, 8'ha9);
		th = th - 12'h1;
		wr(8'h96, {4'h0, th[3:0]});
		wait_irq(1000);
		check({31'h0, irq}, 32'h1);
		rdc(8'h93, 8'he9);
		rdc(8'h97, th[11:4]);
		rdc(8'h96, {4'h0, th[3:0]});
		wr(8'h93, 8'ha9);
		wait_irq(300);
		check({31'h0, irq}, 32'h1);
		wr(8'h93, 8'h80);
		repeat (300) @(posedge clk);
		wr(8'h93, 8'h80);
		rdc(8'h93, 8'h80);
		check({31'h0, smp}, 32'h0);
		$display("test compare done");
		complete_run();
	end

	// bound on the whole run
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		complete_run();
	end
endmodule
